// ---- hw/crg_top.sv ----
// Chip reset generator: power-good, system, host-domain and processor resets
`default_nettype none

module crg_top
    import crg_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = PROC_STRETCH_CYCLES,  // Processor reset stretch
    parameter int unsigned ADDR_W         = 8                     // Wishbone address width
) (
    input  wire logic              clk_i,                 // 50 MHz system clock
    input  wire logic              rst_i,                 // Synchronous reset, active high
    input  wire logic              ce_i,                  // Clock enable, freezes all state
    input  wire crg_pins_s         pins_i,                // Board and host reset pins
    input  wire logic              watchdog_event_i,      // Watchdog event pulse
    input  wire logic              debug_processor_reset_i, // Debug processor-reset bit
    input  wire logic              vw_platform_reset_i,   // Virtual-wire platform reset request
    output crg_resets_s            resets_o,              // Generated resets
    output logic                   irq_o,                 // Level interrupt
    input  wire logic              wb_cyc_i,              // Wishbone cycle
    input  wire logic              wb_stb_i,              // Wishbone strobe
    input  wire logic              wb_we_i,               // Wishbone write enable
    input  wire logic [ADDR_W-1:0] wb_adr_i,              // Wishbone byte address
    input  wire logic [3:0]        wb_sel_i,              // Wishbone byte lanes
    input  wire logic [31:0]       wb_dat_i,              // Wishbone write data
    output logic      [31:0]       wb_dat_o,              // Wishbone read data
    output logic                   wb_ack_o               // Wishbone acknowledge
);

    localparam int unsigned STRETCH_W = $clog2(STRETCH_CYCLES + 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        crg_pg_e                pg_state;
        logic [PG_CNT_W-1:0]    pg_cnt;
        logic [WDT_HOLD_W-1:0]  wdt_hold;
        logic [STRETCH_W-1:0]   stretch_cnt;
        crg_resets_s            rst;
        logic [7:0]             ctrl;
        logic [7:0]             status;
        logic [7:0]             mask;
        logic [7:0]             cause;
        logic [7:0]             prev;
        logic [7:0]             wdt_count;
        logic                   irq;
        logic                   ack;
        logic [31:0]            dat;
    } crg_state_s;

    localparam crg_state_s STATE_RESET = '{
        pg_state:    PG_OFF,
        pg_cnt:      '0,
        wdt_hold:    '0,
        stretch_cnt: '0,
        rst:         '0,
        ctrl:        CTRL_RESET,
        status:      STATUS_RESET,
        mask:        MASK_RESET,
        cause:       STATUS_RESET,
        prev:        '0,
        wdt_count:   '0,
        irq:         1'b0,
        ack:         1'b0,
        dat:         '0
    };

    crg_state_s s_reg;
    crg_state_s s_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge for the low data lane; upper lanes hold no storage
    function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [31:0] data,
                                              input logic [3:0] sel);
        lane_write = sel[0] ? data[7:0] : old;
    endfunction : lane_write

    // Bits that a write-one-to-clear access removes
    function automatic logic [7:0] lane_clear(input logic [31:0] data, input logic [3:0] sel);
        lane_clear = sel[0] ? data[7:0] : 8'h00;
    endfunction : lane_clear

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    crg_pins_s pins_s;

    crg_sync #(
        .WIDTH (PINS_W),
        .INIT  ('0)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (pins_i),
        .q_o   (pins_s)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       wdt_active;
    logic       sys_active;
    logic       host_reset_n;
    logic       platform_n;
    logic       host_active;
    logic       wb_req;
    logic [7:0] events;
    logic [7:0] sources;
    logic [7:0] clr_status;
    logic [7:0] clr_cause;

    always_comb begin
        s_next     = s_reg;
        events     = 8'h00;
        sources    = 8'h00;
        clr_status = 8'h00;
        clr_cause  = 8'h00;

        // delayed rise, immediate fall of always-on power good
        case (s_reg.pg_state)
            PG_OFF: begin
                s_next.pg_cnt = '0;
                if (pins_s.vtr_ok) begin
                    s_next.pg_state = PG_WAIT;
                end
            end
            PG_WAIT: begin
                if (!pins_s.vtr_ok) begin
                    s_next.pg_state = PG_OFF;
                end else if (s_reg.pg_cnt == PG_CNT_W'(PG_DELAY_CYCLES - 1)) begin
                    s_next.pg_state = PG_GOOD;
                end else begin
                    s_next.pg_cnt = s_reg.pg_cnt + PG_CNT_W'(1);
                end
            end
            PG_GOOD: begin
                if (!pins_s.vtr_ok) begin
                    s_next.pg_state = PG_OFF;
                end
            end
            default: begin
                s_next.pg_state = PG_OFF;
            end
        endcase
        s_next.rst.always_on_power_good = (s_next.pg_state == PG_GOOD);

        // watchdog event held as an active reset for a few cycles
        if (watchdog_event_i) begin
            s_next.wdt_hold = WDT_HOLD_W'(WDT_HOLD_CYCLES);
        end else if (s_reg.wdt_hold != '0) begin
            s_next.wdt_hold = s_reg.wdt_hold - WDT_HOLD_W'(1);
        end
        wdt_active = watchdog_event_i || (s_reg.wdt_hold != '0);

        // external pin behaves as an always-on power-on reset
        sources[EVT_EXTIN]  = !pins_s.ext_reset_in_n;
        sources[EVT_PGFAIL] = !s_next.rst.always_on_power_good;
        sources[EVT_WDT]    = wdt_active;
        sources[EVT_DEBUG]  = debug_processor_reset_i;

        sys_active = |sources;
        s_next.rst.system_reset_n = !sys_active;

        platform_n = pins_s.main_rail_power_good && pins_s.espi_reset_n && !vw_platform_reset_i
                     && !s_reg.ctrl[CTRL_PCD_BIT];
        s_next.rst.platform_reset_n = platform_n;

        host_reset_n = s_reg.ctrl[CTRL_HOST_SEL_BIT] ? s_reg.rst.platform_reset_n : pins_s.lpc_reset_n;

        host_active = sys_active || !pins_s.main_rail_power_good || !host_reset_n
                      || !s_reg.ctrl[CTRL_RELEASE_BIT] || wdt_active;
        s_next.rst.host_domain_reset_n = !host_active;

        // external reset output follows host-domain reset
        s_next.rst.ext_reset_out_n = !host_active;

        // processor reset stretched after system reset release
        if (sys_active) begin
            s_next.rst.processor_reset_n = 1'b0;
            s_next.stretch_cnt           = STRETCH_W'(STRETCH_CYCLES);
        end else if (s_reg.stretch_cnt != '0) begin
            s_next.stretch_cnt = s_reg.stretch_cnt - STRETCH_W'(1);
        end else begin
            s_next.stretch_cnt           = '0;
            s_next.rst.processor_reset_n = 1'b1;
        end

        // Events are rising edges of each reset cause
        events = sources & ~s_reg.prev;
        s_next.prev = sources;
        events[EVT_HOST] = host_active && s_reg.rst.host_domain_reset_n;

        // Wishbone slave: one request, answered on the following edge
        wb_req     = wb_cyc_i && wb_stb_i && !s_reg.ack;
        s_next.ack = wb_req;
        s_next.dat = 32'h0000_0000;
        if (wb_req && wb_we_i) begin
            case (wb_adr_i[7:0])
                REG_CTRL_OFS:   s_next.ctrl = lane_write(s_reg.ctrl, wb_dat_i, wb_sel_i);
                REG_STATUS_OFS: clr_status  = lane_clear(wb_dat_i, wb_sel_i);
                REG_MASK_OFS:   s_next.mask = lane_write(s_reg.mask, wb_dat_i, wb_sel_i);
                REG_CAUSE_OFS:  clr_cause   = lane_clear(wb_dat_i, wb_sel_i);
                default:        s_next.ctrl = s_reg.ctrl;  // Unmapped or read-only: ignored
            endcase
        end else if (wb_req) begin
            case (wb_adr_i[7:0])
                REG_CTRL_OFS:   s_next.dat = {24'h00_0000, s_reg.ctrl};
                REG_LEVELS_OFS: s_next.dat = {24'h00_0000, 2'b00, s_reg.rst};
                REG_STATUS_OFS: s_next.dat = {24'h00_0000, s_reg.status};
                REG_MASK_OFS:   s_next.dat = {24'h00_0000, s_reg.mask};
                REG_WDTCNT_OFS: s_next.dat = {24'h00_0000, s_reg.wdt_count};
                REG_CAUSE_OFS:  s_next.dat = {24'h00_0000, s_reg.cause};
                default:        s_next.dat = 32'h0000_0000;
            endcase
        end

        // Sticky status: a new event beats a clear in the same cycle
        s_next.status = (s_reg.status & ~clr_status) | events;
        // Cause bits stay set while a source is still active
        s_next.cause  = (s_reg.cause & ~clr_cause) | sources;

        // event count survives watchdog reset; only rst_i clears it
        if (watchdog_event_i) begin
            s_next.wdt_count = s_reg.wdt_count + 8'h01;
        end

        // system reset initialises always-on control registers
        // watchdog reaches these through system reset
        if (sys_active) begin
            s_next.ctrl = CTRL_RESET;
            s_next.mask = MASK_RESET;
        end

        // Interrupt level from unmasked sticky bits
        s_next.irq = |(s_next.status & s_next.mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Status and event count reset only here, not on system reset, so a reset cause stays readable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= STATE_RESET;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign resets_o = s_reg.rst;
    assign irq_o    = s_reg.irq;
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;

endmodule : crg_top

`default_nettype wire

// ---- hw/crg_pkg.sv ----
// Constants, register map and carrier types of the chip reset generator
`default_nettype none

package crg_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS       = 20;
    localparam int unsigned PG_DELAY_NS         = 10_000;
    localparam int unsigned PG_DELAY_CYCLES     = (PG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PG_CNT_W            = $clog2(PG_DELAY_CYCLES + 1);
    localparam int unsigned PROC_STRETCH_NS     = 1_000_000;
    localparam int unsigned PROC_STRETCH_CYCLES = (PROC_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDT_HOLD_CYCLES     = 4;
    localparam int unsigned WDT_HOLD_W          = $clog2(WDT_HOLD_CYCLES + 1);

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] REG_LEVELS_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS_OFS = 8'h08;
    localparam logic [7:0] REG_MASK_OFS   = 8'h0C;
    localparam logic [7:0] REG_WDTCNT_OFS = 8'h10;
    localparam logic [7:0] REG_CAUSE_OFS  = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_RELEASE_BIT  = 0;   // reset_out_release
    localparam int unsigned CTRL_HOST_SEL_BIT = 1;   // 0: LPC reset pin, 1: platform reset
    localparam int unsigned CTRL_PCD_BIT      = 2;   // peripheral_channel_disable
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  MASK_RESET        = 8'h00;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;

    // Event bits, shared by status, mask and cause registers
    localparam int unsigned EVT_WDT    = 0;
    localparam int unsigned EVT_EXTIN  = 1;
    localparam int unsigned EVT_PGFAIL = 2;
    localparam int unsigned EVT_DEBUG  = 3;
    localparam int unsigned EVT_HOST   = 4;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PG_OFF, PG_WAIT, PG_GOOD} crg_pg_e;

    typedef struct packed {
        logic vtr_ok;                // Always-on rail above threshold
        logic ext_reset_in_n;        // External reset pin
        logic main_rail_power_good;  // Main rail power good pin
        logic lpc_reset_n;           // LPC host reset pin
        logic espi_reset_n;          // eSPI reset pin
    } crg_pins_s;

    localparam int unsigned PINS_W = $bits(crg_pins_s);

    typedef struct packed {
        logic always_on_power_good;
        logic system_reset_n;
        logic host_domain_reset_n;
        logic ext_reset_out_n;
        logic processor_reset_n;
        logic platform_reset_n;
    } crg_resets_s;

endpackage : crg_pkg

`default_nettype wire

// ---- hw/crg_sync.sv ----
// Two-flop synchroniser for a group of pin levels
`default_nettype none

module crg_sync #(
    parameter int unsigned       WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '0
) (
    input  wire logic             clk_i,   // System clock
    input  wire logic             rst_i,   // Synchronous reset, active high
    input  wire logic             ce_i,    // Clock enable
    input  wire logic [WIDTH-1:0] d_i,     // Asynchronous levels
    output logic      [WIDTH-1:0] q_o      // Synchronised levels
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } crg_sync_s;

    crg_sync_s s_reg;
    crg_sync_s s_next;

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    // First stage is read only by the second
    always_comb begin
        s_next      = s_reg;
        s_next.meta = d_i;
        s_next.safe = s_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '{meta: INIT, safe: INIT};
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.safe;

endmodule : crg_sync

`default_nettype wire

// ---- testbench/crg_top_properties.sv ----
// Port-level checker for the chip reset generator
`default_nettype none

module crg_top_properties
    import crg_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = PROC_STRETCH_CYCLES, // Stretch
    parameter int unsigned ADDR_W         = 8                    // Address width
) (
    input wire logic              clk_i,                   // Clock
    input wire logic              rst_i,                   // Reset
    input wire logic              ce_i,                    // Enable
    input wire crg_pins_s         pins_i,                  // Pins
    input wire logic              watchdog_event_i,        // Watchdog
    input wire logic              debug_processor_reset_i, // Debug
    input wire logic              vw_platform_reset_i,     // Virtual wire
    input wire crg_resets_s       resets_o,                // Resets
    input wire logic              irq_o,                   // Interrupt
    input wire logic              wb_cyc_i,                // Cycle
    input wire logic              wb_stb_i,                // Strobe
    input wire logic              wb_we_i,                 // Write
    input wire logic [ADDR_W-1:0] wb_adr_i,                // Address
    input wire logic [3:0]        wb_sel_i,                // Lanes
    input wire logic [31:0]       wb_dat_i,                // Write data
    input wire logic [31:0]       wb_dat_o,                // Read data
    input wire logic              wb_ack_o                 // Acknowledge
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [15:0] rail_cnt; // Cycles the rail pin has been up
    logic [15:0] sys_cnt;  // Cycles since system reset released
    // Saturating, so a long run never wraps into a false match
    always_ff @(posedge clk_i) begin
        rail_cnt <= (rst_i || !pins_i.vtr_ok) ? 16'h0000 : rail_cnt + {15'h0000, rail_cnt != 16'hFFFF};
        sys_cnt  <= (rst_i || !resets_o.system_reset_n) ? 16'h0000 : sys_cnt + {15'h0000, sys_cnt != 16'hFFFF};
    end

    sequence wdt_hold_s;
        !resets_o.system_reset_n [*4];
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_PG_DROP: assert property (!pins_i.vtr_ok [*3] |=> !resets_o.always_on_power_good)
        else $error("power good stayed up after rail loss");
    AST_PG_DELAY: assert property ($rose(resets_o.always_on_power_good) |-> rail_cnt >= PG_DELAY_CYCLES)
        else $error("power good rose too early");
    AST_EXTIN_SYS: assert property (!pins_i.ext_reset_in_n [*3] |=> !resets_o.system_reset_n)
        else $error("external reset did not force system reset");
    AST_SYS_SRC: assert property (debug_processor_reset_i || watchdog_event_i |=> !resets_o.system_reset_n)
        else $error("system reset missed an internal source");
    AST_SYS_REL: assert property ($rose(resets_o.system_reset_n) |-> resets_o.always_on_power_good && !$past(debug_processor_reset_i))
        else $error("system reset released with a source active");
    AST_WDT_HOLD: assert property ($fell(watchdog_event_i) |-> wdt_hold_s)
        else $error("watchdog reset not held");
    AST_WDT_HOST: assert property (watchdog_event_i |=> !resets_o.host_domain_reset_n)
        else $error("watchdog did not reset host domain");
    AST_HOST_ACT: assert property (!resets_o.system_reset_n |=> !resets_o.host_domain_reset_n)
        else $error("host domain released under system reset");
    AST_HOST_REL: assert property ($rose(resets_o.host_domain_reset_n) |-> resets_o.system_reset_n && $past(pins_i.main_rail_power_good, 3))
        else $error("host domain released without main rail");
    AST_EXT_OUT: assert property (resets_o.ext_reset_out_n == resets_o.host_domain_reset_n)
        else $error("reset output differs from host domain reset");
    AST_PROC_SYS: assert property (!resets_o.system_reset_n |-> !resets_o.processor_reset_n)
        else $error("processor reset free while system reset active");
    AST_PROC_LEN: assert property ($rose(resets_o.processor_reset_n) |-> sys_cnt == STRETCH_CYCLES)
        else $error("processor reset stretch wrong");
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_pulse_s)
        else $error("bus acknowledge not a one cycle pulse");
endmodule : crg_top_properties

bind crg_top crg_top_properties #(.STRETCH_CYCLES(STRETCH_CYCLES), .ADDR_W(ADDR_W)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins_i), .watchdog_event_i(watchdog_event_i),
    .debug_processor_reset_i(debug_processor_reset_i), .vw_platform_reset_i(vw_platform_reset_i),
    .resets_o(resets_o), .irq_o(irq_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

`default_nettype wire

// ---- testbench/crg_board_model.sv ----
// Board supplies and host chipset driving the reset pins
`default_nettype none

module crg_board_model
    import crg_pkg::*;
#(
    parameter int unsigned MAIN_DELAY = 8, // Rail ramp, cycles
    parameter int unsigned HOST_DELAY = 4  // Chipset release lag, cycles
) (
    input  wire logic clk_i,     // Clock
    input  wire logic supply_i,  // Always-on supply on
    input  wire logic main_i,    // Main rail requested
    input  wire logic button_i,  // Reset button, low pressed
    input  wire logic lpc_hold_i,  // Chipset holds LPC reset
    input  wire logic espi_hold_i, // Chipset holds eSPI reset
    output var crg_pins_s pins_o // Pin levels
);
    int unsigned main_cnt = 0;
    int unsigned host_cnt = 0;

    initial pins_o = '0;

    // The chipset never frees its resets before the main rail is good
    always @(posedge clk_i) begin
        main_cnt <= (supply_i && main_i) ? main_cnt + (main_cnt < MAIN_DELAY) : 0;
        host_cnt <= pins_o.main_rail_power_good ? host_cnt + (host_cnt < HOST_DELAY) : 0;
        pins_o.vtr_ok <= supply_i;
        pins_o.ext_reset_in_n <= button_i;
        pins_o.main_rail_power_good <= main_cnt == MAIN_DELAY;
        pins_o.lpc_reset_n <= host_cnt == HOST_DELAY && !lpc_hold_i;
        pins_o.espi_reset_n <= host_cnt == HOST_DELAY && !espi_hold_i;
    end
endmodule : crg_board_model

`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the chip reset generator
`default_nettype none

module tb_top;
    import crg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned STRETCH = 20;
    logic clk_i = 0, rst_i = 1, ce_i = 1, wdt = 0, dbg = 0, vw = 0;
    logic supply = 0, main_on = 0, button = 1, lpc_hold = 0, espi_hold = 0;
    logic wb_cyc = 0, wb_stb = 0, wb_we = 0, irq, wb_ack;
    logic [7:0] wb_adr = '0;
    logic [31:0] wb_wdat = '0, wb_rdat, rdat;
    crg_pins_s pins;
    crg_resets_s resets;
    int err_total = 0, total_checks = 0;
    logic [5:0] cases [7] = '{6'h01, 6'h11, 6'h13, 6'h23, 6'h0B, 6'h07, 6'h05};

    initial forever #10 clk_i = ~clk_i;

    crg_board_model u_board (.clk_i(clk_i), .supply_i(supply), .main_i(main_on), .button_i(button),
        .lpc_hold_i(lpc_hold), .espi_hold_i(espi_hold), .pins_o(pins));
    crg_top #(.STRETCH_CYCLES(STRETCH)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins),
        .watchdog_event_i(wdt), .debug_processor_reset_i(dbg), .vw_platform_reset_i(vw),
        .resets_o(resets), .irq_o(irq), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // Classic cycle, bounded wait for ack
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        tick(1);
        if (n >= 20) begin
            chk("bus ack", 1, 0);
            stop_test();
        end
    endtask : wb_xfer

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        wb_xfer(1'b0, adr, '0);
        chk($sformatf("reg %h", adr), exp, rdat & msk);
    endtask : rd_chk

    // Processor stretch count
    task automatic rel_chk(input logic first);
        int k;
        int n;
        k = 0;
        n = 0;
        for (int i = 0; i < 800 && resets.processor_reset_n !== 1'b1; i++) begin
            tick(1);
            k += (resets.always_on_power_good !== 1'b1);
            n += (resets.system_reset_n === 1'b1 && resets.processor_reset_n !== 1'b1);
        end
        chk("proc stretch", STRETCH, n);
        if (first) chk("pg delay", 1, k + 400 >= PG_DELAY_CYCLES);
    endtask : rel_chk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic p, h;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        supply <= 1'b1;
        main_on <= 1'b1;
        tick(400);
        chk("pg early", 0, resets.always_on_power_good);
        rel_chk(1'b1);
        chk("host before release", 0, resets.host_domain_reset_n);
        rd_chk(REG_CTRL_OFS, 0, 32'hFFFF_FFFF);
        $display("test power_up done");
        foreach (cases[i]) begin
            wb_xfer(1'b1, REG_CTRL_OFS, {29'h0000_0000, cases[i][2:0]});
            @(posedge clk_i);
            vw <= cases[i][3];
            lpc_hold <= cases[i][4];
            espi_hold <= cases[i][5];
            tick(8);
            p = !(cases[i][2] | cases[i][3] | cases[i][5]);
            h = cases[i][0] & (cases[i][1] ? p : !cases[i][4]);
            rd_chk(REG_LEVELS_OFS, {26'h000_0000, 2'b11, h, h, 1'b1, p}, 32'hFFFF_FFFF);
        end
        wb_xfer(1'b1, REG_LEVELS_OFS, 32'h0000_00FF);
        rd_chk(REG_LEVELS_OFS, 32'h0000_003E, 32'hFFFF_FFFF);
        rd_chk(8'h20, 0, 32'hFFFF_FFFF);
        $display("test host_paths done");
        wb_xfer(1'b1, REG_CTRL_OFS, 32'h0000_0001);
        @(posedge clk_i);
        vw <= 1'b0;
        lpc_hold <= 1'b0;
        espi_hold <= 1'b0;
        main_on <= 1'b0;
        tick(8);
        rd_chk(REG_LEVELS_OFS, 32'h0000_0032, 32'hFFFF_FFFF);
        @(posedge clk_i);
        main_on <= 1'b1;
        tick(30);
        chk("host after rail", 1, resets.host_domain_reset_n);
        $display("test main_rail done");
        rd_chk(REG_WDTCNT_OFS, 0, 32'hFFFF_FFFF);
        @(posedge clk_i);
        wdt <= 1'b1;
        @(posedge clk_i);
        wdt <= 1'b0;
        #1;
        chk("wdt resets", 0, {resets.system_reset_n, resets.host_domain_reset_n, resets.processor_reset_n});
        rel_chk(1'b0);
        rd_chk(REG_WDTCNT_OFS, 1, 32'hFFFF_FFFF);
        rd_chk(REG_STATUS_OFS, 1, 32'h0000_0001);
        rd_chk(REG_CTRL_OFS, 0, 32'hFFFF_FFFF);
        chk("host held", 0, resets.host_domain_reset_n);
        chk("irq masked", 0, irq);
        wb_xfer(1'b1, REG_MASK_OFS, 32'h0000_0001);
        chk("irq on", 1, irq);
        wb_xfer(1'b1, REG_MASK_OFS, 32'h0000_0000);
        chk("irq mask", 0, irq);
        wb_xfer(1'b1, REG_MASK_OFS, 32'h0000_0001);
        wb_xfer(1'b1, REG_STATUS_OFS, 32'h0000_00FF);
        rd_chk(REG_STATUS_OFS, 0, 32'h0000_0001);
        chk("irq clear", 0, irq);
        $display("test watchdog done");
        @(posedge clk_i);
        button <= 1'b0;
        tick(5);
        chk("ext in", 0, resets.system_reset_n);
        @(posedge clk_i);
        button <= 1'b1;
        rel_chk(1'b0);
        rd_chk(REG_STATUS_OFS, 2, 32'h0000_0002);
        rd_chk(REG_WDTCNT_OFS, 1, 32'hFFFF_FFFF);
        @(posedge clk_i);
        dbg <= 1'b1;
        tick(2);
        chk("debug", 0, {resets.system_reset_n, resets.processor_reset_n});
        @(posedge clk_i);
        dbg <= 1'b0;
        rel_chk(1'b0);
        @(posedge clk_i);
        supply <= 1'b0;
        tick(6);
        chk("rail loss", 0, {resets.always_on_power_good, resets.system_reset_n});
        $display("test sources done");
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
